// [pss_consts.svh]
`ifndef PSS_CONSTS_SVH
`define PSS_CONSTS_SVH
`define PSS_VW 10
`define PSS_DW 16
`define PSS_AW 4
`define PSS_FULL 10'h3e8
`define PSS_TIME_MAX 10'h3e7
`define PSS_CLK_NS 40
`define PSS_TICK_NS 100000
`define PSS_TICK_CYC (`PSS_TICK_NS / `PSS_CLK_NS)
`define PSS_TICK_LAST 12'(`PSS_TICK_CYC - 1)
`define PSS_A_CFG 4'h0
`define PSS_A_DUTY 4'h1
`define PSS_A_BASEUP 4'h2
`define PSS_A_UPLIM 4'h3
`define PSS_A_LOLIM 4'h4
`define PSS_A_RUP 4'h5
`define PSS_A_RDN 4'h6
`define PSS_A_KEY 4'h7
`define PSS_A_COMM 4'h8
`define PSS_A_LOADLIM 4'h9
`define PSS_A_METHOD 4'ha
`define PSS_A_CTRL 4'hb
`define PSS_A_STATUS 4'hc
`define PSS_A_OUT 4'hd
`define PSS_R_DUTY 10'h3e8
`define PSS_R_UPLIM 10'h3e8
`define PSS_R_LOLIM 10'h000
`define PSS_R_RUP 10'h005
`define PSS_R_RDN 10'h000
`define PSS_R_LOADLIM 10'h294
`define PSS_R_CFG 7'h40
`define PSS_NALM 10
`define PSS_NEW_ALM 3
`endif

// [pss_pkg.sv]
package pss_pkg;
  typedef enum logic [1:0] {
    PSS_EV_NONE = 2'b00,
    PSS_EV_METHOD = 2'b01,
    PSS_EV_AUTOMAN = 2'b10,
    PSS_EV_RSVD = 2'b11
  } pss_evassign_t;
  typedef struct packed {
    logic newFirmware;
    logic constCurrent;
    logic autoSrcComm;
    logic manualSrcKey;
    logic autoManualDefault;
    logic [1:0] eventAssign;
  } pss_cfg_t;
  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } pss_bus_t;
endpackage

// [pss_shaper.sv]
`timescale 1ns/10ps
`include "pss_consts.svh"
module pss_shaper
  import pss_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input pss_bus_t bus,
  output logic [15:0] rdata,
  input wire logic [9:0] linearIn,
  input wire logic [9:0] potIn,
  input wire logic eventContact,
  input wire logic resetContact,
  input wire logic [9:0] alarmEvents,
  input wire logic [9:0] loadCurrent,
  output logic [9:0] outValue,
  output logic [9:0] alarmLatched,
  output logic manualMode,
  output logic methodHidden,
  output logic methodCycle,
  output logic opError
);
  // ----------------------------------------
  // Settings
  // ----------------------------------------
  pss_cfg_t cfg_q;
  logic [9:0] duty_q, baseUp_q, upLim_q, loLim_q, rampUpT_q, rampDnT_q;
  logic [9:0] keyVal_q, commVal_q, loadLim_q;
  logic appliedDefault_q;
  logic opError_q, methodCycle_q;
  logic [15:0] rdata_q;
  logic wrMethod;

  function automatic logic [9:0] pssSat(input logic [15:0] v);
    pssSat = (v > 16'(`PSS_FULL)) ? `PSS_FULL : v[9:0];
  endfunction

  function automatic logic [9:0] pssTime(input logic [15:0] v);
    pssTime = (v > 16'(`PSS_TIME_MAX)) ? `PSS_TIME_MAX : v[9:0];
  endfunction

  assign wrMethod = bus.wr && (bus.addr == `PSS_A_METHOD);

  always_ff @(posedge clk) begin
    if (srst) begin
      cfg_q <= `PSS_R_CFG;
      duty_q <= `PSS_R_DUTY;
      baseUp_q <= '0;
      upLim_q <= `PSS_R_UPLIM;
      loLim_q <= `PSS_R_LOLIM;
      rampUpT_q <= `PSS_R_RUP;
      rampDnT_q <= `PSS_R_RDN;
      keyVal_q <= '0;
      commVal_q <= '0;
      loadLim_q <= `PSS_R_LOADLIM;
    end else if (bus.wr) begin
      unique case (bus.addr)
        `PSS_A_CFG: cfg_q <= bus.wdata[6:0];
        `PSS_A_DUTY: duty_q <= pssSat(bus.wdata);
        // Base-up by communications only on constant-current variant
        `PSS_A_BASEUP: if (cfg_q.constCurrent) baseUp_q <= pssSat(bus.wdata);
        `PSS_A_UPLIM: upLim_q <= pssSat(bus.wdata);
        `PSS_A_LOLIM: loLim_q <= pssSat(bus.wdata);
        `PSS_A_RUP: rampUpT_q <= pssTime(bus.wdata);
        `PSS_A_RDN: rampDnT_q <= pssTime(bus.wdata);
        `PSS_A_KEY: keyVal_q <= pssSat(bus.wdata);
        `PSS_A_COMM: commVal_q <= pssSat(bus.wdata);
        `PSS_A_LOADLIM: loadLim_q <= bus.wdata[9:0];
        default: ;
      endcase
    end
  end

  // A changed default waits for a controller reset, so edits never flip the mode mid-run
  always_ff @(posedge clk) begin
    if (srst) begin
      appliedDefault_q <= 1'b0;
    end else if (bus.wr && bus.addr == `PSS_A_CTRL && bus.wdata[0]) begin
      appliedDefault_q <= cfg_q.autoManualDefault;
    end
  end

  // ----------------------------------------
  // Control method select
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      methodCycle_q <= 1'b0;
      opError_q <= 1'b0;
    end else begin
      opError_q <= wrMethod && (cfg_q.eventAssign == PSS_EV_METHOD);
      if (cfg_q.eventAssign == PSS_EV_METHOD && !cfg_q.constCurrent) begin
        methodCycle_q <= eventContact;
      end else if (wrMethod && cfg_q.eventAssign != PSS_EV_METHOD) begin
        methodCycle_q <= bus.wdata[0];
      end
    end
  end

  // ----------------------------------------
  // Source selection
  // ----------------------------------------
  logic manual_q;
  logic [9:0] selVal_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      manual_q <= 1'b0;
    end else if (cfg_q.eventAssign == PSS_EV_AUTOMAN) begin
      manual_q <= eventContact;
    end else begin
      manual_q <= appliedDefault_q;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      selVal_q <= '0;
    end else if (manual_q) begin
      selVal_q <= cfg_q.manualSrcKey ? keyVal_q : potIn;
    end else begin
      selVal_q <= cfg_q.autoSrcComm ? commVal_q : linearIn;
    end
  end

  // ----------------------------------------
  // Scale, base-up, clamp
  // ----------------------------------------
  logic [19:0] product;
  logic [15:0] scaled;
  logic [9:0] unlimited, hiLim, loLim, target_q;

  assign product = duty_q * selVal_q;
  assign scaled = 16'(product / 20'(`PSS_FULL)) + 16'(baseUp_q);
  assign unlimited = pssSat(scaled);
  assign hiLim = (loLim_q > upLim_q) ? loLim_q : upLim_q;
  assign loLim = (loLim_q > upLim_q) ? upLim_q : loLim_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      target_q <= '0;
    end else if (unlimited > hiLim) begin
      target_q <= hiLim;
    end else if (unlimited < loLim) begin
      target_q <= loLim;
    end else begin
      target_q <= unlimited;
    end
  end

  // ----------------------------------------
  // Soft-start ramp
  // ----------------------------------------
  // One unit is 0.1 %; a time T tenths of a second gives one unit per T ticks of 100 us
  logic [11:0] tickCnt_q;
  logic tick;
  logic [9:0] rampAcc_q, ramp_q, stepT;
  logic rising, rampDirUp_q;

  assign tick = (tickCnt_q == `PSS_TICK_LAST);
  assign rising = target_q > ramp_q;
  assign stepT = rising ? rampUpT_q : rampDnT_q;

  always_ff @(posedge clk) begin
    if (srst || tick) begin
      tickCnt_q <= '0;
    end else begin
      tickCnt_q <= tickCnt_q + 12'h001;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ramp_q <= '0;
      rampAcc_q <= '0;
      rampDirUp_q <= 1'b1;
    end else if (target_q == ramp_q) begin
      rampAcc_q <= '0;
    end else if (stepT == '0) begin
      ramp_q <= target_q;
      rampAcc_q <= '0;
    end else if (rising != rampDirUp_q) begin
      // Restart the rate count on a change of direction
      rampDirUp_q <= rising;
      rampAcc_q <= '0;
    end else if (tick) begin
      if (rampAcc_q + 10'h001 >= stepT) begin
        rampAcc_q <= '0;
        ramp_q <= rising ? ramp_q + 10'h001 : ramp_q - 10'h001;
      end else begin
        rampAcc_q <= rampAcc_q + 10'h001;
      end
    end
  end

  // ----------------------------------------
  // Load current limit
  // ----------------------------------------
  // Trim moves one unit per tick, far inside the 500 ms response allowance
  logic [9:0] trim_q;
  logic overCurrent;

  assign overCurrent = cfg_q.constCurrent && !methodCycle_q && (loadCurrent > loadLim_q);

  always_ff @(posedge clk) begin
    if (srst) begin
      trim_q <= '0;
    end else if (!cfg_q.constCurrent || methodCycle_q) begin
      trim_q <= '0;
    end else if (tick && overCurrent && trim_q < ramp_q) begin
      trim_q <= trim_q + 10'h001;
    end else if (tick && !overCurrent && trim_q != '0) begin
      trim_q <= trim_q - 10'h001;
    end
  end

  logic [9:0] outValue_q;
  always_ff @(posedge clk) begin
    if (srst) begin
      outValue_q <= '0;
    end else begin
      outValue_q <= (trim_q > ramp_q) ? '0 : ramp_q - trim_q;
    end
  end

  // ----------------------------------------
  // Alarm latches
  // ----------------------------------------
  logic [9:0] alarm_q;
  generate
    for (genvar i = 0; i < `PSS_NALM; i++) begin : g_alm
      always_ff @(posedge clk) begin
        if (srst) begin
          alarm_q[i] <= 1'b0;
        end else if (alarmEvents[i]) begin
          alarm_q[i] <= 1'b1;
        end else if (resetContact && (i >= `PSS_NEW_ALM || cfg_q.newFirmware)) begin
          alarm_q[i] <= 1'b0;
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  logic methodHidden_q;
  always_ff @(posedge clk) begin
    if (srst) begin
      methodHidden_q <= 1'b0;
    end else begin
      methodHidden_q <= cfg_q.eventAssign == PSS_EV_METHOD;
    end
  end

  always_ff @(posedge clk) begin
    if (srst || !bus.rd) begin
      rdata_q <= '0;
    end else begin
      unique case (bus.addr)
        `PSS_A_CFG: rdata_q <= 16'(cfg_q);
        `PSS_A_DUTY: rdata_q <= 16'(duty_q);
        `PSS_A_BASEUP: rdata_q <= 16'(baseUp_q);
        `PSS_A_UPLIM: rdata_q <= 16'(upLim_q);
        `PSS_A_LOLIM: rdata_q <= 16'(loLim_q);
        `PSS_A_RUP: rdata_q <= 16'(rampUpT_q);
        `PSS_A_RDN: rdata_q <= 16'(rampDnT_q);
        `PSS_A_KEY: rdata_q <= 16'(keyVal_q);
        `PSS_A_COMM: rdata_q <= 16'(commVal_q);
        `PSS_A_LOADLIM: rdata_q <= 16'(loadLim_q);
        `PSS_A_METHOD: rdata_q <= 16'(methodCycle_q);
        `PSS_A_STATUS: rdata_q <= {4'h0, manual_q, methodHidden_q, alarm_q};
        `PSS_A_OUT: rdata_q <= 16'(outValue_q);
        default: rdata_q <= '0;
      endcase
    end
  end

  assign rdata = rdata_q;
  assign outValue = outValue_q;
  assign alarmLatched = alarm_q;
  assign manualMode = manual_q;
  assign methodHidden = methodHidden_q;
  assign methodCycle = methodCycle_q;
  assign opError = opError_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_contactManual;
    cfg_q.eventAssign == PSS_EV_AUTOMAN && eventContact && $stable(cfg_q);
  endsequence
  sequence s_manualFollows;
    manual_q ##1 (selVal_q == ($past(cfg_q.manualSrcKey) ? $past(keyVal_q) : $past(potIn)));
  endsequence
  property p_event_manual;
    @(posedge clk) disable iff (srst) s_contactManual |=> s_manualFollows;
  endproperty
  a_event_manual: assert property (p_event_manual) else $error("manual source not taken from contact");

  property p_event_ignored;
    @(posedge clk) disable iff (srst) cfg_q.eventAssign == PSS_EV_NONE |=> manual_q == $past(appliedDefault_q);
  endproperty
  a_event_ignored: assert property (p_event_ignored) else $error("event contact not ignored");

  sequence s_refusedWrite;
    wrMethod && cfg_q.eventAssign == PSS_EV_METHOD;
  endsequence
  property p_method_refused;
    @(posedge clk) disable iff (srst) s_refusedWrite |=> opError_q ##1 !opError_q || $past(wrMethod);
  endproperty
  a_method_refused: assert property (p_method_refused) else $error("method write not refused");

  property p_alarm_clear;
    @(posedge clk) disable iff (srst) resetContact && alarmEvents == '0 |=> alarm_q[9:3] == '0;
  endproperty
  a_alarm_clear: assert property (p_alarm_clear) else $error("alarm not cleared by reset contact");

  property p_old_fw_keep;
    @(posedge clk) disable iff (srst) !cfg_q.newFirmware && alarmEvents == '0 |=> alarm_q[2:0] == $past(alarm_q[2:0]);
  endproperty
  a_old_fw_keep: assert property (p_old_fw_keep) else $error("relay alarm cleared on old firmware");

  property p_clamp_order;
    @(posedge clk) disable iff (srst) $stable(upLim_q) && $stable(loLim_q) |->
      (target_q <= upLim_q || target_q <= loLim_q) && (target_q >= upLim_q || target_q >= loLim_q);
  endproperty
  a_clamp_order: assert property (p_clamp_order) else $error("output outside limits");

  property p_ramp_rate;
    @(posedge clk) disable iff (srst) rampUpT_q != '0 && rising && $stable(rampUpT_q) |=> ramp_q <= $past(ramp_q) + 10'h001;
  endproperty
  a_ramp_rate: assert property (p_ramp_rate) else $error("ramp rose faster than one unit");

  property p_zero_down;
    @(posedge clk) disable iff (srst) rampDnT_q == '0 && target_q < ramp_q |=> ramp_q == $past(target_q);
  endproperty
  a_zero_down: assert property (p_zero_down) else $error("zero down time did not jump");

  property p_trim_grows;
    @(posedge clk) disable iff (srst) tick && overCurrent && trim_q < ramp_q |=> trim_q == $past(trim_q) + 10'h001;
  endproperty
  a_trim_grows: assert property (p_trim_grows) else $error("overcurrent trim not applied");

  sequence s_contactAuto;
    cfg_q.eventAssign == PSS_EV_AUTOMAN && !eventContact;
  endsequence
  sequence s_autoFollows;
    !manual_q ##1 (selVal_q == ($past(cfg_q.autoSrcComm) ? $past(commVal_q) : $past(linearIn)));
  endsequence
  property p_auto_source;
    @(posedge clk) disable iff (srst) s_contactAuto |=> s_autoFollows;
  endproperty
  a_auto_source: assert property (p_auto_source) else $error("automatic source not taken");

  property p_alarm_set;
    @(posedge clk) disable iff (srst) alarmEvents != '0 |=> (alarm_q & $past(alarmEvents)) == $past(alarmEvents);
  endproperty
  a_alarm_set: assert property (p_alarm_set) else $error("alarm event not latched");

  property p_method_kept;
    @(posedge clk) disable iff (srst) wrMethod && cfg_q.eventAssign == PSS_EV_METHOD && cfg_q.constCurrent |=>
      methodCycle_q == $past(methodCycle_q);
  endproperty
  a_method_kept: assert property (p_method_kept) else $error("refused method write changed method");

  property p_zero_up;
    @(posedge clk) disable iff (srst) rampUpT_q == '0 && target_q > ramp_q |=> ramp_q == $past(target_q);
  endproperty
  a_zero_up: assert property (p_zero_up) else $error("zero up time did not jump");

  property p_ramp_hold;
    @(posedge clk) disable iff (srst) rampUpT_q != '0 && target_q >= ramp_q && !tick |=> ramp_q == $past(ramp_q);
  endproperty
  a_ramp_hold: assert property (p_ramp_hold) else $error("ramp moved between ticks");

  property p_trim_released;
    @(posedge clk) disable iff (srst) tick && !overCurrent && trim_q != '0 && cfg_q.constCurrent && !methodCycle_q |=>
      trim_q == $past(trim_q) - 10'h001;
  endproperty
  a_trim_released: assert property (p_trim_released) else $error("trim not released");

  sequence s_ctrlReset;
    bus.wr && bus.addr == `PSS_A_CTRL && bus.wdata[0] && cfg_q.eventAssign != PSS_EV_AUTOMAN;
  endsequence
  property p_default_applied;
    @(posedge clk) disable iff (srst) s_ctrlReset |-> ##2 manual_q == $past(cfg_q.autoManualDefault, 2);
  endproperty
  a_default_applied: assert property (p_default_applied) else $error("default not applied on reset");
endmodule

// [pss_far_side.sv]
`timescale 1ns/10ps
module pss_far_side (
  input wire logic clk,
  output logic [9:0] linearIn,
  output logic [9:0] potIn,
  output logic eventContact,
  output logic resetContact,
  output logic [9:0] alarmEvents,
  output logic [9:0] loadCurrent
);
  // ----------------------------------------
  // Analog source and contacts
  // ----------------------------------------
  // Load current idles at zero; only load() pushes it over the limit
  initial begin
    linearIn = 10'h000;
    potIn = 10'h000;
    eventContact = 1'b0;
    resetContact = 1'b0;
    alarmEvents = 10'h000;
    loadCurrent = 10'h000;
  end
  task automatic drive(input logic [9:0] lin, input logic [9:0] pot, input logic ev, input logic rs);
    @(posedge clk);
    linearIn <= lin;
    potIn <= pot;
    eventContact <= ev;
    resetContact <= rs;
  endtask
  // Detections are single-cycle, so latching is the only memory of them
  task automatic pulseAlarms(input logic [9:0] m);
    @(posedge clk);
    alarmEvents <= m;
    @(posedge clk);
    alarmEvents <= 10'h000;
  endtask
  task automatic load(input logic [9:0] cur);
    @(posedge clk);
    loadCurrent <= cur;
  endtask
endmodule

// [pss_tb.sv]
`timescale 1ns/10ps
`include "pss_consts.svh"
module tb import pss_pkg::*;;
  logic clk;
  logic srst;
  pss_bus_t bus;
  logic [15:0] rdata;
  logic [9:0] linearIn;
  logic [9:0] potIn;
  logic eventContact;
  logic resetContact;
  logic [9:0] alarmEvents;
  logic [9:0] loadCurrent;
  logic [9:0] outValue;
  logic [9:0] alarmLatched;
  logic manualMode;
  logic methodHidden;
  logic methodCycle;
  logic opError;
  logic [15:0] lf;
  int badCount;
  int checked;

  pss_shaper uut (.clk(clk), .srst(srst), .bus(bus), .rdata(rdata), .linearIn(linearIn), .potIn(potIn),
    .eventContact(eventContact), .resetContact(resetContact), .alarmEvents(alarmEvents),
    .loadCurrent(loadCurrent), .outValue(outValue), .alarmLatched(alarmLatched), .manualMode(manualMode),
    .methodHidden(methodHidden), .methodCycle(methodCycle), .opError(opError));
  pss_far_side fs (.clk(clk), .linearIn(linearIn), .potIn(potIn), .eventContact(eventContact),
    .resetContact(resetContact), .alarmEvents(alarmEvents), .loadCurrent(loadCurrent));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ----------------------------------------
  // Helpers and reference model
  // ----------------------------------------
  function automatic int rnd();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return int'(lf) % 1001;
  endfunction
  // Floor division matches the 0.1% resolution of the datapath
  function automatic int model(int inV, int duty, int bu, int a, int b);
    int v;
    v = duty * inV / 1000 + bu;
    if (v > 1000) v = 1000;
    if (v > ((a > b) ? a : b)) v = (a > b) ? a : b;
    if (v < ((a > b) ? b : a)) v = (a > b) ? b : a;
    return v;
  endfunction
  task automatic chk(input logic ok, input string msg);
    checked++;
    if (ok !== 1'b1) begin
      badCount++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  task automatic wr(input logic [3:0] a, input int d);
    @(posedge clk);
    bus <= '{addr: a, wdata: 16'(d), wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask
  task automatic rdChk(input logic [3:0] a, input logic [15:0] exp, input string msg);
    @(posedge clk);
    bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1;
    chk(rdata === exp, msg);
  endtask
  task automatic waitOut(input int exp, input string msg);
    repeat (4) @(posedge clk);
    #1;
    for (int n = 0; n < 20 && outValue !== 10'(exp); n++) begin
      @(posedge clk);
      #1;
    end
    chk(outValue === 10'(exp), msg);
  endtask
  task automatic waitMode(input logic exp, input string msg);
    #1;
    for (int n = 0; n < 20 && manualMode !== exp; n++) begin
      @(posedge clk);
      #1;
    end
    chk(manualMode === exp, msg);
  endtask
  task automatic alarmRound(input logic [9:0] left, input string msg);
    fs.pulseAlarms(10'h3ff);
    repeat (2) @(posedge clk);
    #1;
    chk(alarmLatched === 10'h3ff, "alarms not latched");
    fs.drive(10'h000, 10'h000, 1'b0, 1'b1);
    fs.drive(10'h000, 10'h000, 1'b0, 1'b0);
    repeat (3) @(posedge clk);
    #1;
    chk(alarmLatched === left, msg);
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", checked, badCount);
    if (badCount == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    int lin, duty, bu, ua, ub, n;
    srst = 1'b1;
    bus = '0;
    lf = 16'he486;
    badCount = 0;
    checked = 0;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    rdChk(`PSS_A_UPLIM, 16'h03e8, "upper limit default");
    rdChk(`PSS_A_LOLIM, 16'h0000, "lower limit default");
    rdChk(`PSS_A_RUP, 16'h0005, "up time default");
    rdChk(`PSS_A_RDN, 16'h0000, "down time default");
    rdChk(4'he, 16'h0000, "unmapped read");
    wr(`PSS_A_RUP, 1200);
    rdChk(`PSS_A_RUP, 16'h03e7, "time above maximum");
    wr(`PSS_A_RUP, 0);
    wr(`PSS_A_CFG, 16'h0060);
    for (int i = 0; i < 12; i++) begin
      lin = rnd();
      duty = rnd();
      bu = rnd() / 4;
      ua = rnd();
      ub = rnd();
      wr(`PSS_A_DUTY, duty);
      wr(`PSS_A_BASEUP, bu);
      wr(`PSS_A_UPLIM, ua);
      wr(`PSS_A_LOLIM, ub);
      fs.drive(10'(lin), 10'h000, 1'b0, 1'b0);
      waitOut(model(lin, duty, bu, ua, ub), "shaped output");
    end
    wr(`PSS_A_CFG, 16'h0042);
    fs.drive(10'h064, 10'h1c2, 1'b1, 1'b0);
    waitMode(1'b1, "contact did not select manual");
    waitOut(model(450, duty, bu, ua, ub), "resistor value not used");
    fs.drive(10'h064, 10'h1c2, 1'b0, 1'b0);
    waitMode(1'b0, "contact did not select automatic");
    waitOut(model(100, duty, bu, ua, ub), "linear value not used");
    wr(`PSS_A_CFG, 16'h0044);
    fs.drive(10'h064, 10'h1c2, 1'b1, 1'b0);
    repeat (10) @(posedge clk);
    #1;
    chk(manualMode === 1'b0, "contact or default acted early");
    wr(`PSS_A_CTRL, 1);
    waitMode(1'b1, "default not applied on controller reset");
    wr(`PSS_A_CFG, 16'h0061);
    repeat (3) @(posedge clk);
    #1;
    chk(methodHidden === 1'b1, "method setting not hidden");
    wr(`PSS_A_METHOD, 1);
    n = 0;
    repeat (4) begin
      #1;
      if (opError === 1'b1) n++;
      @(posedge clk);
    end
    chk(n == 1 && methodCycle === 1'b0, "method write not refused once");
    wr(`PSS_A_CFG, 16'h0040);
    alarmRound(10'h000, "reset contact left alarms");
    wr(`PSS_A_CFG, 16'h0000);
    alarmRound(10'h007, "older firmware cleared relay alarms");
    wr(`PSS_A_BASEUP, 7);
    rdChk(`PSS_A_BASEUP, 16'(bu), "base-up taken without constant current");
    // Back to automatic with no base-up and full limits for the ramp
    wr(`PSS_A_CFG, 16'h0060);
    wr(`PSS_A_CTRL, 1);
    wr(`PSS_A_DUTY, 1000);
    wr(`PSS_A_BASEUP, 0);
    wr(`PSS_A_UPLIM, 1000);
    wr(`PSS_A_LOLIM, 0);
    fs.drive(10'h320, 10'h000, 1'b0, 1'b0);
    waitOut(800, "full duty output not reached");
    wr(`PSS_A_RUP, 1);
    fs.drive(10'h000, 10'h000, 1'b0, 1'b0);
    waitOut(0, "no immediate fall with zero down time");
    fs.drive(10'h005, 10'h000, 1'b0, 1'b0);
    repeat (3 * 2500) @(posedge clk);
    #1;
    chk(outValue >= 10'h002 && outValue <= 10'h004, "rise not gradual");
    repeat (3 * 2500) @(posedge clk);
    waitOut(5, "ramp did not reach target");
    wr(`PSS_A_RUP, 0);
    fs.drive(10'h320, 10'h000, 1'b0, 1'b0);
    waitOut(800, "output before overload");
    fs.load(10'h2bc);
    repeat (3 * 2500) @(posedge clk);
    #1;
    chk(outValue >= 10'h31d && outValue <= 10'h31e, "overload not trimmed");
    fs.load(10'h000);
    repeat (4 * 2500) @(posedge clk);
    waitOut(800, "trim not released");
    summarize();
  end
endmodule
